// file: rtl/dfs_consts.svh
`ifndef DFS_CONSTS_SVH
`define DFS_CONSTS_SVH
// Register offsets
`define DFS_ADDR_SELECT 8'h10
`define DFS_ADDR_FEATURE 8'h11
`define DFS_ADDR_CHAN_BASE 8'h12
`define DFS_ADDR_MIX_BASE 8'h18
`define DFS_ADDR_MUTE_STAT 8'h30
// Feature field positions
`define DFS_ROUTE_HI 15
`define DFS_ROUTE_LO 14
`define DFS_EMPH_HI 13
`define DFS_EMPH_LO 11
`define DFS_POL_BIT 10
`define DFS_MUTE_BIT 9
`define DFS_FAST_BIT 8
`define DFS_VOL_HI 7
`define DFS_VOL_LO 0
// Select register field positions
`define DFS_MIXEN_HI 13
`define DFS_MIXEN_LO 8
`define DFS_SEL_HI 7
`define DFS_SEL_LO 6
`define DFS_CHEN_HI 5
`define DFS_CHEN_LO 0
// Reset values
`define DFS_FEATURE_RST 16'h0000
`define DFS_SELECT_RST 16'h0000
// Write masks per feature group
`define DFS_MASK_ALL 16'hffff
`define DFS_MASK_VOL 16'h00ff
`define DFS_MASK_MUTE 16'h0300
`define DFS_MASK_TONE 16'hfc00
// Storage masks per channel kind
`define DFS_KEEP_CH_ODD 16'hffff
`define DFS_KEEP_CH_EVEN 16'h3fff
`define DFS_KEEP_MIX_ODD 16'hc7ff
`define DFS_KEEP_MIX_EVEN 16'h07ff
// Volume law
`define DFS_VOL_FINE_MAX 8'hd4
`define DFS_VOL_SILENT 8'hfc
`define DFS_ATTEN_SILENT 10'h3ff
`define DFS_NUM_CHAN 6
`endif

// file: rtl/dfs_pkg.sv
package dfs_pkg;
  typedef enum logic [1:0] {
    DFS_GRP_ALL, DFS_GRP_VOL, DFS_GRP_MUTE, DFS_GRP_TONE
  } dfs_group_type;
  typedef enum logic [2:0] {
    DFS_EMPH_OFF, DFS_EMPH_32K, DFS_EMPH_44K1, DFS_EMPH_48K,
    DFS_EMPH_96K, DFS_EMPH_UNUSED
  } dfs_emph_type;
  typedef enum logic [1:0] {
    DFS_SRC_LEFT, DFS_SRC_RIGHT
  } dfs_src_type;
  typedef struct packed {
    logic [1:0] inputRouting;
    logic [2:0] emphasisFilter;
    logic polarityInvert;
    logic outputMute;
    logic fastMuteMode;
    logic [7:0] volumeAtten;
  } dfs_feature_type;
  typedef struct packed {
    dfs_src_type oddSrc;
    dfs_src_type evenSrc;
    dfs_emph_type emph;
    logic invert;
    logic mute;
    logic fastMute;
    logic [9:0] attenQdb;
  } dfs_pair_ctl_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dfs_bus_req_type;
endpackage

// file: rtl/dfs_feature_regs.sv
`timescale 1ns/1ps
`include "dfs_consts.svh"
// Overview of operation
// - Selector picks all, volume, mute or tone
// - Feature word at 11H with fixed fields
// - All feature fields reset to zero
// - Routing field steers left/right to pair
// - Decode de-emphasis codes, top three unused
// - Polarity bit inverts DAC output
// - Mute bit silences affected outputs
// - Outputs muted after start-up
// - Fast-mute bit picks quick or soft
// - Coarse region: 3 dB per four codes
// - Per-channel volume; top codes fully silent
// - Only selected group fields change in channel registers
// - Only enabled channel registers take write
// - Even channels never store routing
// - Mixing channels never store de-emphasis
module dfs_feature_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire dfs_pkg::dfs_bus_req_type busReq,
  output logic [15:0] rdData,
  // Per-pair DAC controls, pairs 1/2, 3/4, 5/6
  output dfs_pkg::dfs_pair_ctl_type [2:0] pairCtl,
  // Per-channel attenuation in quarter dB, all ones is silence
  output logic [5:0][9:0] chanAtten,
  output logic [5:0][9:0] mixAtten,
  output logic [5:0] chanMute
);
  import dfs_pkg::*;

  // ****************************************************
  // Register decode
  // ****************************************************
  logic [15:0] featureWord_r;
  logic [15:0] selectWord_r;
  logic [15:0] chanReg_r [0:5];
  logic [15:0] mixReg_r [0:5];
  logic startMute_r;
  logic [15:0] rdData_r;

  wire wrSelect = busReq.wr && busReq.addr == `DFS_ADDR_SELECT;
  wire wrFeature = busReq.wr && busReq.addr == `DFS_ADDR_FEATURE;
  wire [1:0] selField = selectWord_r[`DFS_SEL_HI:`DFS_SEL_LO];
  wire [5:0] chanEn = selectWord_r[`DFS_CHEN_HI:`DFS_CHEN_LO];
  wire [5:0] mixEn = selectWord_r[`DFS_MIXEN_HI:`DFS_MIXEN_LO];
  wire dfs_group_type grp = dfs_group_type'(selField);
  logic [15:0] grpMask;

  always_comb begin
    unique case (grp)
      DFS_GRP_ALL: grpMask = `DFS_MASK_ALL;
      DFS_GRP_VOL: grpMask = `DFS_MASK_VOL;
      DFS_GRP_MUTE: grpMask = `DFS_MASK_MUTE;
      DFS_GRP_TONE: grpMask = `DFS_MASK_TONE;
    endcase
  end

  // ****************************************************
  // Feature and select registers
  // ****************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      featureWord_r <= `DFS_FEATURE_RST;
      selectWord_r <= `DFS_SELECT_RST;
    end else begin
      if (wrFeature) begin
        featureWord_r <= busReq.wdata;
      end
      if (wrSelect) begin
        selectWord_r <= busReq.wdata;
      end
    end
  end

  // Start-up mute holds until the host writes a cleared mute bit in the all or mute group with a chanEn bit set
  wire muteClearWr = wrFeature && !busReq.wdata[`DFS_MUTE_BIT] &&
                     grpMask[`DFS_MUTE_BIT] && (chanEn != 6'h00);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startMute_r <= 1'b1;
    end else if (muteClearWr) begin
      startMute_r <= 1'b0;
    end
  end

  // ****************************************************
  // Channel registers
  // ****************************************************
  genvar gi;
  generate
    for (gi = 0; gi < `DFS_NUM_CHAN; gi++) begin : g_chan
      // Channel index 0 is channel 1, an odd channel
      localparam logic [15:0] CH_KEEP =
        (gi % 2 == 0) ? `DFS_KEEP_CH_ODD : `DFS_KEEP_CH_EVEN;
      localparam logic [15:0] MIX_KEEP =
        (gi % 2 == 0) ? `DFS_KEEP_MIX_ODD : `DFS_KEEP_MIX_EVEN;
      wire [15:0] chWrMask = grpMask & CH_KEEP;
      wire [15:0] mxWrMask = grpMask & MIX_KEEP;
      wire [15:0] chNxt = (chanReg_r[gi] & ~chWrMask) |
                          (busReq.wdata & chWrMask);
      wire [15:0] mxNxt = (mixReg_r[gi] & ~mxWrMask) |
                          (busReq.wdata & mxWrMask);
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          chanReg_r[gi] <= `DFS_FEATURE_RST;
          mixReg_r[gi] <= `DFS_FEATURE_RST;
        end else if (wrFeature) begin
          if (chanEn[gi]) begin
            chanReg_r[gi] <= chNxt;
          end
          if (mixEn[gi]) begin
            mixReg_r[gi] <= mxNxt;
          end
        end
      end
    end
  endgenerate

  // ****************************************************
  // Volume law
  // ****************************************************
  function automatic logic [9:0] vol_to_qdb(input logic [7:0] code);
    logic [7:0] step;
    logic [9:0] qdb;
    step = 8'h00;
    qdb = 10'h000;
    if (code >= `DFS_VOL_SILENT) begin
      qdb = `DFS_ATTEN_SILENT;
    end else if (code <= `DFS_VOL_FINE_MAX) begin
      qdb = {2'b00, code};
    end else begin
      // Each step of four codes adds 12 quarter dB
      step = (code - `DFS_VOL_FINE_MAX) >> 2;
      qdb = 10'({2'b00, `DFS_VOL_FINE_MAX}) +
            10'(12 * step);
    end
    return qdb;
  endfunction

  // ****************************************************
  // Output decode
  // ****************************************************
  dfs_pair_ctl_type [2:0] pairNxt;
  logic [5:0][9:0] chanAttenNxt;
  logic [5:0][9:0] mixAttenNxt;
  logic [5:0] chanMuteNxt;
  // Reset image of the pair controls: straight routing, muted
  localparam dfs_pair_ctl_type PAIR_RST = '{
    oddSrc: DFS_SRC_LEFT, evenSrc: DFS_SRC_RIGHT, emph: DFS_EMPH_OFF,
    invert: 1'b0, mute: 1'b1, fastMute: 1'b0, attenQdb: 10'h000
  };

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      dfs_feature_type odd;
      odd = dfs_feature_type'(chanReg_r[2*p]);
      unique case (odd.inputRouting)
        2'b00: begin
          pairNxt[p].oddSrc = DFS_SRC_LEFT;
          pairNxt[p].evenSrc = DFS_SRC_RIGHT;
        end
        2'b01: begin
          pairNxt[p].oddSrc = DFS_SRC_LEFT;
          pairNxt[p].evenSrc = DFS_SRC_LEFT;
        end
        2'b10: begin
          pairNxt[p].oddSrc = DFS_SRC_RIGHT;
          pairNxt[p].evenSrc = DFS_SRC_RIGHT;
        end
        2'b11: begin
          pairNxt[p].oddSrc = DFS_SRC_RIGHT;
          pairNxt[p].evenSrc = DFS_SRC_LEFT;
        end
      endcase
      pairNxt[p].emph = (odd.emphasisFilter > 3'h4) ?
        DFS_EMPH_UNUSED : dfs_emph_type'(odd.emphasisFilter);
      pairNxt[p].invert = odd.polarityInvert;
      pairNxt[p].mute = odd.outputMute | startMute_r;
      pairNxt[p].fastMute = odd.fastMuteMode;
      pairNxt[p].attenQdb = vol_to_qdb(odd.volumeAtten);
    end
    for (int c = 0; c < 6; c++) begin
      chanAttenNxt[c] = vol_to_qdb(chanReg_r[c][`DFS_VOL_HI:`DFS_VOL_LO]);
      mixAttenNxt[c] = vol_to_qdb(mixReg_r[c][`DFS_VOL_HI:`DFS_VOL_LO]);
      chanMuteNxt[c] = chanReg_r[c][`DFS_MUTE_BIT] | startMute_r;
    end
  end

  // ****************************************************
  // Read mux
  // ****************************************************
  wire [7:0] rdIdxCh = busReq.addr - `DFS_ADDR_CHAN_BASE;
  wire [7:0] rdIdxMx = busReq.addr - `DFS_ADDR_MIX_BASE;
  wire hitCh = busReq.addr >= `DFS_ADDR_CHAN_BASE && rdIdxCh < 8'h06;
  wire hitMx = busReq.addr >= `DFS_ADDR_MIX_BASE && rdIdxMx < 8'h06;
  wire [15:0] rdMux =
    (busReq.addr == `DFS_ADDR_SELECT) ? selectWord_r :
    (busReq.addr == `DFS_ADDR_FEATURE) ? featureWord_r :
    hitCh ? chanReg_r[rdIdxCh[2:0]] :
    hitMx ? mixReg_r[rdIdxMx[2:0]] :
    (busReq.addr == `DFS_ADDR_MUTE_STAT) ? {15'h0000, startMute_r} :
    16'h0000;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= 16'h0000;
      pairCtl <= {3{PAIR_RST}};
      chanAtten <= '0;
      mixAtten <= '0;
      chanMute <= 6'h3f;
    end else begin
      rdData_r <= busReq.rd ? rdMux : 16'h0000;
      pairCtl <= pairNxt;
      chanAtten <= chanAttenNxt;
      mixAtten <= mixAttenNxt;
      chanMute <= chanMuteNxt;
    end
  end
  assign rdData = rdData_r;

  // ****************************************************
  // Checks
  // ****************************************************
  chk_startup_mute: assert property (
    @(posedge clk) disable iff (!rst_b)
    startMute_r |-> ##1 (chanMute == 6'h3f))
    else $error("outputs not muted at start-up");
  chk_silent_codes: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[0][7:0] >= 8'hfc) |=> (chanAtten[0] == 10'h3ff))
    else $error("top volume codes not silent");
  chk_fine_volume: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[1][7:0] <= 8'hd4) |=>
      (chanAtten[1] == {2'b00, $past(chanReg_r[1][7:0])}))
    else $error("fine volume wrong");
  chk_even_routing: assert property (
    @(posedge clk) disable iff (!rst_b)
    chanReg_r[1][15:14] == 2'b00)
    else $error("even channel holds routing");
  chk_mix_emph: assert property (
    @(posedge clk) disable iff (!rst_b)
    mixReg_r[0][13:11] == 3'b000)
    else $error("mixing channel holds de-emphasis");
  chk_disabled_keep: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && !chanEn[2]) |=> $stable(chanReg_r[2]))
    else $error("disabled channel changed");
  chk_group_keep: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && grp == DFS_GRP_VOL) |=>
      (chanReg_r[0][15:8] == $past(chanReg_r[0][15:8])))
    else $error("volume write changed other fields");
  chk_invert_follow: assert property (
    @(posedge clk) disable iff (!rst_b)
    ##1 (pairCtl[0].invert == $past(chanReg_r[0][10])))
    else $error("polarity not applied");
  chk_swap_route: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[2][15:14] == 2'b11) |=>
      (pairCtl[1].oddSrc == DFS_SRC_RIGHT))
    else $error("swap routing wrong");
  chk_pair_startup: assert property (
    @(posedge clk) disable iff (!rst_b)
    startMute_r |=>
      (pairCtl[0].mute && pairCtl[1].mute && pairCtl[2].mute))
    else $error("pair not muted at start-up");
  chk_mute_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    (startMute_r && !muteClearWr) |=> startMute_r)
    else $error("start-up mute dropped without clearing write");
  chk_chan_mute: assert property (
    @(posedge clk) disable iff (!rst_b)
    chanReg_r[0][9] |=> chanMute[0])
    else $error("mute bit not applied");
  chk_route_straight: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[4][15:14] == 2'b00) |=> (pairCtl[2].oddSrc == DFS_SRC_LEFT
      && pairCtl[2].evenSrc == DFS_SRC_RIGHT))
    else $error("straight routing wrong");
  chk_emph_code: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[0][13:11] == 3'h4) |=>
      (pairCtl[0].emph == DFS_EMPH_96K))
    else $error("de-emphasis code not decoded");
  chk_emph_unused: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[0][13:11] > 3'h4) |=>
      (pairCtl[0].emph == DFS_EMPH_UNUSED))
    else $error("unused de-emphasis code not flagged");
  chk_fast_follow: assert property (
    @(posedge clk) disable iff (!rst_b)
    ##1 (pairCtl[2].fastMute == $past(chanReg_r[4][8])))
    else $error("fast mute mode not applied");
  chk_coarse_volume: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[0][7:0] == 8'hf8) |=> (chanAtten[0] == 10'h140))
    else $error("coarse volume end point wrong");
  chk_coarse_round: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[0][7:0] == 8'hdb) |=> (chanAtten[0] == 10'h0e0))
    else $error("coarse volume not rounded down");
  chk_pair_silent: assert property (
    @(posedge clk) disable iff (!rst_b)
    (chanReg_r[2][7:0] >= 8'hfc) |=>
      (pairCtl[1].attenQdb == 10'h3ff))
    else $error("pair attenuation not silent");
  chk_feature_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    wrFeature |=> (featureWord_r == $past(busReq.wdata)))
    else $error("feature word not stored");
  chk_read_feature: assert property (
    @(posedge clk) disable iff (!rst_b)
    (busReq.rd && busReq.addr == `DFS_ADDR_FEATURE) |=>
      (rdData == $past(featureWord_r)))
    else $error("feature read data wrong");
  chk_idle_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    !busReq.rd |=> (rdData == 16'h0000))
    else $error("read data not zero when idle");
  chk_all_copy: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && grp == DFS_GRP_ALL && chanEn[0]) |=>
      (chanReg_r[0] == $past(busReq.wdata)))
    else $error("all-feature write not copied");
  chk_vol_copy: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && grp == DFS_GRP_VOL && chanEn[3]) |=>
      (chanReg_r[3][7:0] == $past(busReq.wdata[7:0])))
    else $error("volume write not copied");
  chk_mute_keep: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && grp == DFS_GRP_MUTE) |=>
      (chanReg_r[0][7:0] == $past(chanReg_r[0][7:0])))
    else $error("mute write changed volume");
  chk_tone_keep: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && grp == DFS_GRP_TONE) |=>
      (chanReg_r[0][9:0] == $past(chanReg_r[0][9:0])))
    else $error("tone write changed mute or volume");
  chk_mix_even: assert property (
    @(posedge clk) disable iff (!rst_b)
    mixReg_r[1][15:11] == 5'h00)
    else $error("even mixing channel holds routing or de-emphasis");
  chk_disabled_mix: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wrFeature && !mixEn[0]) |=> $stable(mixReg_r[0]))
    else $error("disabled mixing channel changed");
endmodule

// file: verification/dfs_feature_regs_tb.sv
`timescale 1ns/1ps
module dfs_feature_regs_tb;
  import dfs_pkg::*;
  logic clk;
  logic rst_b;
  dfs_bus_req_type busReq;
  logic [15:0] rdData;
  dfs_pair_ctl_type [2:0] pairCtl;
  logic [5:0][9:0] chanAtten;
  logic [5:0][9:0] mixAtten;
  logic [5:0] chanMute;
  int error_cnt;
  int checked;
  // Volume code beside the expected quarter-dB attenuation
  logic [17:0] volRow [11] = '{
    {8'h00, 10'h000}, {8'h01, 10'h001}, {8'h35, 10'h035},
    {8'hd4, 10'h0d4}, {8'hd5, 10'h0d4}, {8'hd8, 10'h0e0},
    {8'hdb, 10'h0e0}, {8'hf8, 10'h140}, {8'hfb, 10'h140},
    {8'hfc, 10'h3ff}, {8'hff, 10'h3ff}
  };

  dfs_feature_regs uut (.clk(clk), .rst_b(rst_b), .busReq(busReq),
    .rdData(rdData), .pairCtl(pairCtl), .chanAtten(chanAtten),
    .mixAtten(mixAtten), .chanMute(chanMute));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp,
                    input string name);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1 chk(name, rdData, exp);
  endtask

  // Outputs follow a write one edge after it is taken
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    busReq = '0;
    repeat (4) @(posedge clk);
    #1 chk("muteRst", chanMute, 16'h003f);
    chk("attRst", chanAtten[0], 16'h0000);
    chk("pairMuteRst", pairCtl[1].mute, 16'h0001);
    chk("evenRst", pairCtl[2].evenSrc, DFS_SRC_RIGHT);
    @(posedge clk) rst_b <= 1'b1;
    rd(8'h11, 16'h0000, "featRst");
    rd(8'h30, 16'h0001, "statRst");
    wr(8'h10, 16'h3f7f);
    foreach (volRow[i]) begin
      wr(8'h11, {8'h00, volRow[i][17:10]});
      settle();
      chk("chAtt0", chanAtten[0], volRow[i][9:0]);
      chk("chAtt5", chanAtten[5], volRow[i][9:0]);
      chk("mxAtt2", mixAtten[2], volRow[i][9:0]);
      chk("pairAtt", pairCtl[1].attenQdb, volRow[i][9:0]);
    end
    chk("muteHeld", chanMute, 16'h003f);
    wr(8'h10, 16'h00bf);
    wr(8'h11, 16'h0000);
    settle();
    chk("muteClr", chanMute, 16'h0000);
    rd(8'h30, 16'h0000, "statClr");
    wr(8'h10, 16'h0085);
    wr(8'h11, 16'h0300);
    settle();
    chk("muteSet", chanMute, 16'h0005);
    chk("fast0", pairCtl[0].fastMute, 16'h0001);
    chk("fast2", pairCtl[2].fastMute, 16'h0000);
    chk("volKeep", chanAtten[2], 16'h03ff);
    wr(8'h10, 16'h00ff);
    for (int i = 0; i < 8; i++) begin
      wr(8'h11, {i[1:0], i[2:0], i[0], 10'h000});
      settle();
      chk("oddSrc", pairCtl[2].oddSrc,
          i[1] ? DFS_SRC_RIGHT : DFS_SRC_LEFT);
      chk("evenSrc", pairCtl[2].evenSrc,
          i[0] ? DFS_SRC_LEFT : DFS_SRC_RIGHT);
      chk("emph", pairCtl[0].emph,
          (i < 5) ? 16'(i) : 16'(DFS_EMPH_UNUSED));
      chk("inv", pairCtl[1].invert, i[0]);
      chk("keepMute", pairCtl[1].mute, 16'h0001);
    end
    wr(8'h10, 16'h2002);
    wr(8'h11, 16'h0010);
    settle();
    chk("ch2Att", chanAtten[1], 16'h0010);
    chk("ch1Att", chanAtten[0], 16'h03ff);
    chk("mx6Att", mixAtten[5], 16'h0010);
    chk("mx5Att", mixAtten[4], 16'h03ff);
    wr(8'h10, 16'h0303);
    wr(8'h11, 16'hffff);
    settle();
    rd(8'h10, 16'h0303, "selRd");
    rd(8'h11, 16'hffff, "featRd");
    rd(8'h12, 16'hffff, "ch1Rd");
    rd(8'h13, 16'h3fff, "ch2Rd");
    rd(8'h18, 16'hc7ff, "mx1Rd");
    rd(8'h19, 16'h07ff, "mx2Rd");
    rd(8'h05, 16'h0000, "unmapped");
    wr(8'h40, 16'h1234);
    rd(8'h11, 16'hffff, "featKeep");
    // Second reset in mid-run
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("muteRst2", chanMute, 16'h003f);
    chk("attRst2", chanAtten[1], 16'h0000);
    chk("pairMuteRst2", pairCtl[0].mute, 16'h0001);
    @(posedge clk) rst_b <= 1'b1;
    rd(8'h12, 16'h0000, "ch1Rst");
    rd(8'h30, 16'h0001, "statRst2");
    end_sim();
  end
endmodule
